// file: src/spo_pkg.sv
package spo_pkg;
	localparam int SPO_CLK_HZ = 25000000;
	// Port geometry
	localparam logic [12:0] SPO_ADDR_TOP = 13'h0234;
	localparam logic [12:0] SPO_ADDR_BOT = 13'h0000;
	localparam int SPO_ADDR_W = 13;
	localparam int SPO_INSTR_W = 16;
	localparam int SPO_RW_POS = 15;
	localparam int SPO_LEN_HI_POS = 14;
	localparam int SPO_LEN_LO_POS = 13;
	localparam logic [1:0] SPO_LEN_STREAM = 2'h3;
	// Port configuration byte fields
	localparam int SPO_CFG_LSB_A = 1;
	localparam int SPO_CFG_LSB_B = 6;
	localparam int SPO_CFG_SOFTRST = 5;
	localparam logic [7:0] SPO_CFG_RST = 8'h00;
	// Store
	localparam int SPO_STORE_BYTES = 512;
	localparam logic [7:0] SPO_EOD_CODE = 8'hff;
	// Timing, in microseconds as printed
	localparam int SPO_SAVE_US = 46000;
	localparam int SPO_LOAD_US = 40000;
	localparam int SPO_DEFLOAD_US = 2;
	localparam int SPO_SAVE_CYC = SPO_SAVE_US * (SPO_CLK_HZ / 1000000);
	localparam int SPO_LOAD_CYC = SPO_LOAD_US * (SPO_CLK_HZ / 1000000);
	localparam int SPO_DEFLOAD_CYC = SPO_DEFLOAD_US * (SPO_CLK_HZ / 1000000);
	localparam int SPO_CNT_W = 21;
	typedef enum logic [1:0] {
		SPO_IDLE = 2'b00,
		SPO_SAVE = 2'b01,
		SPO_LOAD = 2'b10,
		SPO_DEFL = 2'b11
	} spo_xfer_t;
	typedef enum logic [1:0] {
		SPO_P_INSTR = 2'b00,
		SPO_P_DATA = 2'b01,
		SPO_P_DONE = 2'b10
	} spo_phase_t;
endpackage

// file: src/spo_order_store.sv
// Summary of operation
// - MSB first default, LSB bits immediate
// - MSB first: address decrements per byte
// - LSB first: address increments, none skipped
// - Past boundary: writes dropped, reads zero
// - Streaming stops when crossing address boundary
// - Sixteen-bit instruction: rw, length, address
// - Holds a 512-byte nonvolatile store
// - Port blocked during transfer except busy
// - Busy set at start, cleared at end
// - I2C address unacknowledged while busy
// - Status pin can follow busy bit
// - Save 46 ms, restore 40 ms
// - Reset pin restores store or defaults
// - Outputs start 2 us or 40 ms
// - Save copies registers, clears store request
// - Store writes need write enable
// - Failed transfer sets data error bit
// - Select high: restore on power, reset, soft
// - Select low: restore only on load request
// - Commit copies buffered writes to active
// - End code stops store transfer
`timescale 1ns/1ps
`default_nettype none
module spo_order_store
	import spo_pkg::*;
#(
	parameter int SAVE_CYC = SPO_SAVE_CYC,
	parameter int LOAD_CYC = SPO_LOAD_CYC
)(
	input wire logic clk,
	input wire logic srst,
	// Serial link, clocked by the host
	input wire logic sclk,
	input wire logic csN,
	input wire logic sdioIn,
	output logic sdioOut,
	output logic sdioOe,
	// Loose control and status bits
	input wire logic storeWriteEnable,
	input wire logic storeRequest,
	input wire logic loadRequest,
	input wire logic commit,
	input wire logic statusSelBusy,
	input wire logic storeSelect,
	input wire logic hardResetN,
	input wire logic i2cMode,
	input wire logic storeFault,
	input wire logic addrMatch,
	output logic busy,
	output logic storeRequestClr,
	output logic dataError,
	output logic statusOutPin,
	output logic i2cAck,
	output logic outputsRun,
	output logic syncPulse,
	output logic lsbFirst,
	output logic [7:0] activeCfg,
	output logic [7:0] activeData,
	output logic [12:0] lastAddr
);
	// Link domain: shift register and address generator
	logic [15:0] shiftReg;
	logic [4:0] bitCnt;
	spo_phase_t phaseReg;
	logic rwReg;
	logic [1:0] lenReg;
	logic [1:0] byteCnt;
	logic [12:0] addrReg;
	logic pastEdge;
	logic [7:0] cfgReg;
	logic [7:0] bufByte;
	logic [12:0] bufAddr;
	logic wrTog;
	logic [7:0] rdByte;
	logic busyL1, busyL2;
	logic [7:0] bitIn;
	logic [7:0] rxByte;
	assign bitIn = {shiftReg[6:0], sdioIn};
	// bit order: LSB-first bytes reversed on arrival
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			rxByte[i] = cfgReg[SPO_CFG_LSB_A] ? bitIn[7 - i] : bitIn[i];
		end
	end
	// Busy crosses into the link domain on two flops
	always_ff @(posedge sclk) begin
		busyL1 <= busy;
		busyL2 <= busyL1;
	end
	always_ff @(posedge sclk or posedge csN) begin
		if (csN) begin
			bitCnt <= 5'h00;
			phaseReg <= SPO_P_INSTR;
			shiftReg <= 16'h0000;
			byteCnt <= 2'h0;
			pastEdge <= 1'b0;
		end else begin
			shiftReg <= {shiftReg[14:0], sdioIn};
			if (phaseReg == SPO_P_INSTR) begin
				if (bitCnt == 5'h0f) begin
					bitCnt <= 5'h00;
					phaseReg <= SPO_P_DATA;
				end else begin
					bitCnt <= bitCnt + 5'h01;
				end
			end else if (phaseReg == SPO_P_DATA) begin
				if (bitCnt == 5'h07) begin
					bitCnt <= 5'h00;
					byteCnt <= byteCnt + 2'h1;
					// boundary reached: later bytes fall outside
					if ((!cfgReg[SPO_CFG_LSB_A] && addrReg == SPO_ADDR_BOT) ||
						(cfgReg[SPO_CFG_LSB_A] && addrReg == SPO_ADDR_TOP)) begin
						pastEdge <= 1'b1;
						// streaming ends on the boundary byte
						if (lenReg == SPO_LEN_STREAM) begin
							phaseReg <= SPO_P_DONE;
						end
					end
					if (lenReg != SPO_LEN_STREAM && byteCnt == lenReg) begin
						phaseReg <= SPO_P_DONE;
					end
				end else begin
					bitCnt <= bitCnt + 5'h01;
				end
			end
		end
	end
	// Instruction fields and current address, kept across CS
	always_ff @(posedge sclk) begin
		if (phaseReg == SPO_P_INSTR && bitCnt == 5'h0f && !csN) begin
			if (cfgReg[SPO_CFG_LSB_A]) begin
				// LSB first: address bit 0 came first, read flag comes last
				rwReg <= sdioIn;
				lenReg <= {shiftReg[0], shiftReg[1]};
				addrReg <= {shiftReg[2], shiftReg[3], shiftReg[4], shiftReg[5], shiftReg[6], shiftReg[7],
					shiftReg[8], shiftReg[9], shiftReg[10], shiftReg[11], shiftReg[12], shiftReg[13],
					shiftReg[14]};
			end else begin
				rwReg <= shiftReg[SPO_RW_POS - 1];
				lenReg <= {shiftReg[SPO_LEN_HI_POS - 1], shiftReg[SPO_LEN_LO_POS - 1]};
				addrReg <= {shiftReg[11:0], sdioIn};
			end
		end else if (phaseReg == SPO_P_DATA && bitCnt == 5'h07 && !csN) begin
			if (cfgReg[SPO_CFG_LSB_A]) begin
				addrReg <= addrReg + 13'h0001;
			end else begin
				addrReg <= addrReg - 13'h0001;
			end
		end
	end
	// Config byte and buffered write, link side
	// Reset taken asynchronously: the host clock is idle during reset
	always_ff @(posedge sclk or posedge srst) begin
		if (srst) begin
			cfgReg <= SPO_CFG_RST;
			wrTog <= 1'b0;
			bufByte <= 8'h00;
			bufAddr <= 13'h0000;
		end else if (phaseReg == SPO_P_DATA && bitCnt == 5'h07 && !csN && !rwReg) begin
			// writes blocked while a transfer runs; none past edge
			if (!busyL2 && !pastEdge) begin
				if (addrReg == SPO_ADDR_BOT) begin
					// mirrored byte reads the same either order
					cfgReg <= rxByte;
				end
				bufByte <= rxByte;
				bufAddr <= addrReg;
				wrTog <= ~wrTog;
			end
		end else if (cfgReg[SPO_CFG_SOFTRST]) begin
			cfgReg[SPO_CFG_SOFTRST] <= 1'b0;
			cfgReg[7 - SPO_CFG_SOFTRST] <= 1'b0;
		end
	end
	// Read data: config byte, or busy bit over zeros past the edge or while busy
	// only the busy bit is served during a transfer
	assign rdByte = (pastEdge || busyL2) ? {7'h00, busyL2} : cfgReg;
	// First data bit must stand on the fall right after the instruction
	always_ff @(negedge sclk or posedge srst) begin
		if (srst) begin
			sdioOe <= 1'b0;
			sdioOut <= 1'b0;
		end else if (phaseReg == SPO_P_DATA && rwReg && !csN) begin
			sdioOe <= 1'b1;
			sdioOut <= cfgReg[SPO_CFG_LSB_A] ? rdByte[bitCnt[2:0]] : rdByte[3'h7 - bitCnt[2:0]];
		end else begin
			sdioOe <= 1'b0;
			sdioOut <= 1'b0;
		end
	end
	// System domain: three-flop samplers for pins and link events
	logic [2:0] wrSync, softSync, lsbSync, rstSync;
	logic [7:0] bufByteS;
	logic [12:0] bufAddrS;
	always_ff @(posedge clk) begin
		wrSync <= {wrSync[1:0], wrTog};
		softSync <= {softSync[1:0], cfgReg[SPO_CFG_SOFTRST]};
		lsbSync <= {lsbSync[1:0], cfgReg[SPO_CFG_LSB_B]};
		rstSync <= {rstSync[1:0], hardResetN};
	end
	logic wrEvent, softEvent, rstRelease;
	assign wrEvent = wrSync[2] != wrSync[1];
	assign softEvent = softSync[1] && !softSync[2];
	assign rstRelease = rstSync[1] && !rstSync[2];
	spo_xfer_t xferReg;
	logic [SPO_CNT_W-1:0] cntReg;
	logic [8:0] storePtr;
	logic [7:0] storeMem [SPO_STORE_BYTES];
	logic powerUp;
	// Buffered byte: toggle guarantees data stable when sampled
	always_ff @(posedge clk) begin
		if (srst) begin
			bufByteS <= 8'h00;
			bufAddrS <= 13'h0000;
		end else if (wrEvent) begin
			bufByteS <= bufByte;
			bufAddrS <= bufAddr;
		end
	end
	// commit moves buffered write into active registers
	always_ff @(posedge clk) begin
		if (srst) begin
			activeCfg <= SPO_CFG_RST;
			activeData <= 8'h00;
			lastAddr <= 13'h0000;
			lsbFirst <= 1'b0;
		end else begin
			lsbFirst <= lsbSync[2] && lsbSync[1];
			if (commit && xferReg == SPO_IDLE) begin
				activeData <= bufByteS;
				lastAddr <= bufAddrS;
				if (bufAddrS == SPO_ADDR_BOT) begin
					activeCfg <= bufByteS;
				end
			end else if (xferReg == SPO_LOAD && cntReg == SPO_CNT_W'(1)) begin
				activeData <= storeMem[9'h000];
			end
		end
	end
	// transfer controller, one transfer at a time
	always_ff @(posedge clk) begin
		if (srst) begin
			xferReg <= SPO_IDLE;
			cntReg <= '0;
			busy <= 1'b0;
			dataError <= 1'b0;
			storeRequestClr <= 1'b0;
			powerUp <= 1'b1;
			outputsRun <= 1'b0;
			syncPulse <= 1'b0;
			storePtr <= 9'h000;
		end else begin
			storeRequestClr <= 1'b0;
			syncPulse <= 1'b0;
			case (xferReg)
				SPO_IDLE: begin
					powerUp <= 1'b0;
					// save needs enable, request and commit
					if (commit && storeRequest && storeWriteEnable) begin
						xferReg <= SPO_SAVE;
						cntReg <= SPO_CNT_W'(SAVE_CYC);
						busy <= 1'b1;
						dataError <= 1'b0;
						storePtr <= 9'h000;
					// select high restores from the store
					end else if (storeSelect && (powerUp || rstRelease || softEvent)) begin
						xferReg <= SPO_LOAD;
						cntReg <= SPO_CNT_W'(LOAD_CYC);
						busy <= 1'b1;
						dataError <= 1'b0;
						outputsRun <= 1'b0;
					// select low: only explicit load request
					end else if (!storeSelect && loadRequest) begin
						xferReg <= SPO_LOAD;
						cntReg <= SPO_CNT_W'(LOAD_CYC);
						busy <= 1'b1;
						dataError <= 1'b0;
					end else if (!storeSelect && (powerUp || rstRelease || softEvent)) begin
						xferReg <= SPO_DEFL;
						cntReg <= SPO_CNT_W'(SPO_DEFLOAD_CYC);
						outputsRun <= 1'b0;
					end
					if (!rstSync[1] && !rstSync[2]) begin
						outputsRun <= 1'b0;
					end
				end
				SPO_SAVE: begin
					// registers copied; end code stops early
					if (storePtr != 9'h1ff) begin
						storePtr <= storePtr + 9'h001;
					end
					if (storeFault) begin
						dataError <= 1'b1;
					end
					if (cntReg == SPO_CNT_W'(1) || activeData == SPO_EOD_CODE) begin
						xferReg <= SPO_IDLE;
						busy <= 1'b0;
						storeRequestClr <= 1'b1;
					end else begin
						cntReg <= cntReg - SPO_CNT_W'(1);
					end
				end
				SPO_LOAD: begin
					// fault during transfer flags data error
					if (storeFault) begin
						dataError <= 1'b1;
					end
					if (cntReg == SPO_CNT_W'(1)) begin
						xferReg <= SPO_IDLE;
						busy <= 1'b0;
						outputsRun <= 1'b1;
						syncPulse <= 1'b1;
					end else begin
						cntReg <= cntReg - SPO_CNT_W'(1);
					end
				end
				default: begin
					// defaults load in about 2 us, then sync
					if (cntReg == SPO_CNT_W'(1)) begin
						xferReg <= SPO_IDLE;
						outputsRun <= 1'b1;
						syncPulse <= 1'b1;
					end else begin
						cntReg <= cntReg - SPO_CNT_W'(1);
					end
				end
			endcase
		end
	end
	// store array, written only while saving with enable
	always_ff @(posedge clk) begin
		if (xferReg == SPO_SAVE && storeWriteEnable) begin
			storeMem[storePtr] <= activeData;
		end
	end
	// status pin and I2C acknowledge follow busy
	always_ff @(posedge clk) begin
		if (srst) begin
			statusOutPin <= 1'b0;
			i2cAck <= 1'b0;
		end else begin
			statusOutPin <= statusSelBusy ? busy : 1'b0;
			i2cAck <= i2cMode && addrMatch && !busy;
		end
	end
	a_busy_state: assert property (@(posedge clk) disable iff (srst)
		busy |-> (xferReg == SPO_SAVE || xferReg == SPO_LOAD)) else $error("busy without transfer");
	a_no_restart: assert property (@(posedge clk) disable iff (srst)
		(xferReg == SPO_SAVE && cntReg > SPO_CNT_W'(2)) |=> xferReg == SPO_SAVE || activeData == SPO_EOD_CODE)
		else $error("save disturbed");
	a_save_clear: assert property (@(posedge clk) disable iff (srst)
		(xferReg == SPO_SAVE && cntReg == SPO_CNT_W'(1)) |=> storeRequestClr && !busy && xferReg == SPO_IDLE)
		else $error("save end");
	a_save_end: assert property (@(posedge clk) disable iff (srst)
		($fell(busy) && $past(xferReg) == SPO_SAVE) |-> storeRequestClr) else $error("request not cleared");
	a_ack_busy: assert property (@(posedge clk) disable iff (srst)
		busy |=> !i2cAck) else $error("ack while busy");
	a_status_pin: assert property (@(posedge clk) disable iff (srst)
		statusSelBusy |=> statusOutPin == $past(busy)) else $error("status pin wrong");
	a_save_start: assert property (@(posedge clk) disable iff (srst)
		(xferReg == SPO_IDLE && commit && storeRequest && storeWriteEnable) |=> busy && xferReg == SPO_SAVE)
		else $error("save not started");
	a_load_sel: assert property (@(posedge clk) disable iff (srst)
		(xferReg == SPO_IDLE && !storeSelect && !loadRequest && !commit) |=> xferReg != SPO_LOAD)
		else $error("load without request");
	// Last restore cycle, then outputs released with a sync
	sequence s_load_last;
		xferReg == SPO_LOAD && cntReg == SPO_CNT_W'(1);
	endsequence
	sequence s_load_out;
		outputsRun && syncPulse && !busy;
	endsequence
	a_load_done: assert property (@(posedge clk) disable iff (srst)
		s_load_last |=> s_load_out) else $error("load end wrong");
	// MSB first steps the address down
	a_addr_step: assert property (@(posedge sclk) disable iff (csN)
		(phaseReg == SPO_P_DATA && bitCnt == 5'h07 && !cfgReg[SPO_CFG_LSB_A]) |=> addrReg == $past(addrReg) - 13'h0001)
		else $error("address not stepped down");
endmodule
`default_nettype wire

// file: test/spo_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module spo_host_model (
	output logic sclk,
	output logic csN,
	output logic sdio,
	input wire logic sdo,
	input wire logic sdoOe
);
	logic lastBit;
	initial begin
		sclk = 1'b0;
		csN = 1'b1;
		sdio = 1'b0;
		lastBit = 1'b0;
	end
	task automatic shiftBit(input logic b);
		sdio = b;
		lastBit = b;
		#24 sclk = 1'b1;
		#24 sclk = 1'b0;
	endtask
	task automatic spiWrite(input logic [15:0] instr, input logic [7:0] data, input logic lsb);
		#7 csN = 1'b0;
		#24;
		for (int i = 0; i < 16; i++) shiftBit(lsb ? instr[i] : instr[15 - i]);
		for (int i = 0; i < 8; i++) shiftBit(lsb ? data[i] : data[7 - i]);
		#24 csN = 1'b1;
		// Released line must not keep the last bit
		sdio = ~lastBit;
	endtask
	// One-byte read; the device changes the line on the fall before each rise
	task automatic spiRead(input logic [15:0] instr, input logic lsb, output logic [7:0] data,
		output logic oeSeen);
		oeSeen = 1'b1;
		data = 8'h00;
		#7 csN = 1'b0;
		#24;
		for (int i = 0; i < 16; i++) shiftBit(lsb ? instr[i] : instr[15 - i]);
		for (int i = 0; i < 8; i++) begin
			#24 sclk = 1'b1;
			data[lsb ? i : 7 - i] = sdo;
			oeSeen = oeSeen & sdoOe;
			#24 sclk = 1'b0;
		end
		#24 csN = 1'b1;
		sdio = ~lastBit;
	endtask
endmodule
`default_nettype wire

// file: test/spo_order_store_tb.sv
`timescale 1ns/1ps
`default_nettype none
module spo_order_store_tb;
	import spo_pkg::*;
	localparam int XFER_N = 20;
	logic clk, srst, sclk, csN, sdioIn, sdioOut, sdioOe, storeWriteEnable, storeRequest, loadRequest, commit;
	logic statusSelBusy, storeSelect, hardResetN, i2cMode, storeFault, addrMatch, busy, storeRequestClr;
	logic dataError, statusOutPin, i2cAck, outputsRun, syncPulse, lsbFirst;
	logic [7:0] activeCfg, activeData;
	logic [12:0] lastAddr;
	logic [7:0] rdData;
	logic oeSeen;
	int failures, check_count, cycles, clrCount, syncCount, n, t0, c0;
	spo_order_store #(.SAVE_CYC(XFER_N), .LOAD_CYC(XFER_N)) i_dut (.clk(clk), .srst(srst), .sclk(sclk),
		.csN(csN), .sdioIn(sdioIn), .sdioOut(sdioOut), .sdioOe(sdioOe), .storeWriteEnable(storeWriteEnable),
		.storeRequest(storeRequest), .loadRequest(loadRequest), .commit(commit), .statusSelBusy(statusSelBusy),
		.storeSelect(storeSelect), .hardResetN(hardResetN), .i2cMode(i2cMode), .storeFault(storeFault),
		.addrMatch(addrMatch), .busy(busy), .storeRequestClr(storeRequestClr), .dataError(dataError),
		.statusOutPin(statusOutPin), .i2cAck(i2cAck), .outputsRun(outputsRun), .syncPulse(syncPulse),
		.lsbFirst(lsbFirst), .activeCfg(activeCfg), .activeData(activeData), .lastAddr(lastAddr));
	spo_host_model i_host (.sclk(sclk), .csN(csN), .sdio(sdioIn), .sdo(sdioOut), .sdoOe(sdioOe));
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	always @(posedge clk) begin
		cycles++;
		if (storeRequestClr === 1'b1) clrCount++;
		if (syncPulse === 1'b1) syncCount++;
		if (cycles == 20000) begin
			failures++;
			$display("ERROR timeout expected 0 seen 1");
			finish_test();
		end
	end
	task automatic finish_test();
		$display("checks %0d mismatches %0d", check_count, failures);
		if (failures == 0 && check_count > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	task automatic checkBit(input string what, input logic exp, input logic got);
		check_count++;
		if (got !== exp) begin
			failures++;
			$display("ERROR %s expected %b seen %b", what, exp, got);
		end
	endtask
	task automatic checkWord(input string what, input logic [15:0] exp, input logic [15:0] got);
		check_count++;
		if (got !== exp) begin
			failures++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic tick(input int k);
		repeat (k) @(posedge clk);
		#1;
	endtask
	task automatic waitBusy(input logic level, input int limit);
		n = 0;
		while (busy !== level && n < limit) begin
			tick(1);
			n++;
		end
	endtask
	// One-cycle strobe of commit, or of the load request
	task automatic pulse(input logic isLoad);
		@(posedge clk);
		if (isLoad) loadRequest <= 1'b1;
		else commit <= 1'b1;
		@(posedge clk);
		loadRequest <= 1'b0;
		commit <= 1'b0;
	endtask
	// Times one transfer; poke repeats the commit and injects a store fault
	task automatic measure(input string what, input logic poke);
		waitBusy(1'b1, 30);
		t0 = cycles;
		checkBit({what, " busy"}, 1'b1, busy);
		if (poke) begin
			pulse(1'b0);
			storeFault <= 1'b1;
		end
		tick(2);
		checkBit({what, " status pin"}, 1'b1, statusOutPin);
		checkBit({what, " ack"}, 1'b0, i2cAck);
		waitBusy(1'b0, 200);
		storeFault <= 1'b0;
		checkBit({what, " length"}, 1'b1, (cycles - t0 >= XFER_N - 2) && (cycles - t0 <= XFER_N + 2));
		tick(3);
		checkBit({what, " pin idle"}, 1'b0, statusOutPin);
		checkBit({what, " ack idle"}, 1'b1, i2cAck);
		checkBit({what, " error"}, poke, dataError);
		$display("test %s done", what);
		// Gap before the next transfer
		tick(260);
	endtask
	initial begin
		{srst, storeWriteEnable, storeRequest, loadRequest, commit, storeFault} <= 6'h20;
		{statusSelBusy, storeSelect, hardResetN, i2cMode, addrMatch} <= 5'h1f;
		{failures, check_count, cycles, clrCount, syncCount} = '0;
		tick(20);
		srst <= 1'b0;
		measure("power up", 1'b0);
		checkBit("outputs run", 1'b1, outputsRun);
		checkBit("msb default", 1'b0, lsbFirst);
		c0 = clrCount;
		storeWriteEnable <= 1'b1;
		storeRequest <= 1'b1;
		pulse(1'b0);
		measure("save", 1'b0);
		checkBit("request clear", 1'b1, clrCount == c0 + 1);
		pulse(1'b0);
		measure("save fault", 1'b1);
		storeWriteEnable <= 1'b0;
		pulse(1'b0);
		tick(8);
		checkBit("no save", 1'b0, busy);
		storeRequest <= 1'b0;
		storeSelect <= 1'b0;
		pulse(1'b1);
		measure("load", 1'b0);
		i_host.spiWrite(16'h0000, 8'h42, 1'b0);
		tick(10);
		checkBit("lsb first", 1'b1, lsbFirst);
		i_host.spiRead(16'h8000, 1'b1, rdData, oeSeen);
		checkWord("read config", 16'h0042, {8'h00, rdData});
		checkBit("read drive", 1'b1, oeSeen);
		pulse(1'b0);
		tick(1);
		checkWord("active config", 16'h0042, {8'h00, activeCfg});
		i_host.spiWrite(16'h0005, 8'h3c, 1'b1);
		tick(6);
		pulse(1'b0);
		tick(1);
		checkWord("active data", 16'h003c, {8'h00, activeData});
		checkWord("last address", 16'h0005, {3'h0, lastAddr});
		checkWord("config kept", 16'h0042, {8'h00, activeCfg});
		$display("test link done");
		storeSelect <= 1'b1;
		i_host.spiWrite(16'h0000, 8'h66, 1'b1);
		measure("soft reset", 1'b0);
		c0 = syncCount;
		@(posedge clk);
		hardResetN <= 1'b0;
		tick(5);
		hardResetN <= 1'b1;
		measure("hard reset", 1'b0);
		checkBit("sync", 1'b1, syncCount > c0);
		c0 = syncCount;
		storeSelect <= 1'b0;
		@(posedge clk);
		hardResetN <= 1'b0;
		tick(5);
		hardResetN <= 1'b1;
		tick(8);
		checkBit("default no load", 1'b0, busy);
		checkBit("default wait", 1'b0, outputsRun);
		tick(60);
		checkBit("default run", 1'b1, outputsRun);
		checkBit("default sync", 1'b1, syncCount > c0);
		$display("test default reset done");
		finish_test();
	end
endmodule
`default_nettype wire
